/* File: verilog/stim_bank_pkg.sv */
// Purpose: Shared constants and carriers for the stimulator bank control
// Assumes: 200 MHz clock, register port with one-cycle read latency
// Notes: Offsets are byte addresses of 32-bit words
package stim_bank_pkg;

    // Clock and time base
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned MS_PS = 1000000000;
    localparam int unsigned MS_CYCLES = MS_PS / CLK_PERIOD_PS;

    // Indicator periods and off-bank pulse width in milliseconds
    localparam logic [11:0] SYNC_PERIOD_MS = 12'h3e8;
    localparam logic [11:0] OFF_PERIOD_MS = 12'hbb8;
    localparam logic [11:0] OFF_PULSE_MS = 12'h064;
    localparam logic [11:0] FAST_PERIOD_MS = 12'h0fa;
    localparam logic [11:0] SLOW_PERIOD_MS = 12'h5dc;
    localparam logic [11:0] HV_PERIOD_MS = 12'h1f4;

    // Register offsets
    localparam logic [5:0] ADDR_STIM_SEL = 6'h00;
    localparam logic [5:0] ADDR_RET_SEL = 6'h04;
    localparam logic [5:0] ADDR_BANK_EN = 6'h08;
    localparam logic [5:0] ADDR_CONFIG = 6'h0c;
    localparam logic [5:0] ADDR_DOUT = 6'h10;
    localparam logic [5:0] ADDR_STATUS = 6'h14;
    localparam logic [5:0] ADDR_INT_STAT = 6'h18;
    localparam logic [5:0] ADDR_INT_MASK = 6'h1c;
    localparam logic [5:0] ADDR_CHAN_STATE = 6'h20;

    // Fields and reset values
    localparam int unsigned CFG_GLOBAL_REF_BIT = 0;
    localparam logic [3:0] BANK_EN_RST = 4'hf;
    localparam logic [15:0] ALL_CH_MASK = 16'hffff;
    localparam logic [15:0] FOUR_CH_MASK = 16'h000f;

    // Interrupt event positions
    localparam int unsigned EV_CONFLICT = 0;
    localparam int unsigned EV_LINK_LOST = 1;
    localparam int unsigned EV_LINK_UP = 2;
    localparam int unsigned EV_BAT_LOW = 3;
    localparam int unsigned EV_HV_LOW = 4;

    typedef enum logic [2:0] {
        MODE_OPEN = 3'b001,
        MODE_STIM = 3'b010,
        MODE_RET = 3'b100
    } chan_mode_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [5:0] addr;
        logic [31:0] wdata;
    } bus_req_s;

    typedef struct packed {
        logic valid;
        logic is_ctrl;
        logic [5:0] addr;
        logic [15:0] data;
    } link_word_s;

    typedef struct packed {
        logic hv_low;
        logic hv_ok;
        logic bat_low;
        logic bat_chg;
        logic link_ok;
    } status_pins_s;

    typedef struct packed {
        logic [15:0] stim_sel;
        logic [15:0] ret_sel;
        logic [3:0] bank_en;
        logic global_ref;
        logic [15:0] dout;
        logic [4:0] int_stat;
        logic [4:0] int_mask;
        chan_mode_e [15:0] mode;
        logic [3:0] conflict;
        logic [3:0] bank_pwr;
        logic [31:0] ms_cnt;
        logic [11:0] ms_time;
        logic [4:0] sync1;
        logic [4:0] sync2;
        logic [4:0] sync3;
        logic [4:0] lvl;
        logic [31:0] rdata;
        logic [31:0] chan_state;
        logic dac_valid;
        logic [15:0] dac_data;
        logic [15:0] stim_led;
        logic [15:0] ret_led;
        logic sync_led;
        logic gref_led;
        logic bat_led;
        logic hv_led;
        logic [15:0] ctl_led;
        logic irq;
    } ctrl_state_s;

    localparam ctrl_state_s STATE_RST = '{
        mode: '{default: MODE_OPEN},
        bank_en: BANK_EN_RST,
        default: '0
    };

endpackage : stim_bank_pkg

/* File: verilog/stim_bank_ctrl.sv */
// Purpose: Channel mode, bank power, indicators and control outputs
// Assumes: Link words arrive already deserialised on this clock
// Notes: Register port writes win over link writes in the same cycle
//
// Contract
// - Four or sixteen channels, four-channel banks, bank power
// - Each channel is stimulate, reference or open
// - Stim and ref in bank shuts bank (code shuts it only when a single channel is selected for both)
// - Stim light per channel while stimulating
// - Powered-off bank lights pulse every three seconds
// - Ref light per channel while reference
// - Link light blinks unlinked, steady when linked
// - Global reference light while global return used
// - Battery light fast charging, slow when low
// - High voltage light steady good, blinking low
// - Sixteen control outputs written as one word
// - Control light per output while high
// - Link carries samples, control and channel state
// - All channels open after power-up
`timescale 1ns/1ps
`default_nettype none

module stim_bank_ctrl #(
    parameter int unsigned NUM_CH = 16,
    parameter int unsigned MS_CYCLES = stim_bank_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // Register port
    input wire stim_bank_pkg::bus_req_s bus_i,
    output logic [31:0] rdata_o,
    // Link side
    input wire stim_bank_pkg::link_word_s link_i,
    output logic [31:0] chan_state_o,
    output logic dac_valid_o,
    output logic [15:0] dac_data_o,
    // Status pins
    input wire stim_bank_pkg::status_pins_s pins_i,
    // Bank power and channel lights
    output logic [3:0] bank_pwr_o,
    output logic [15:0] stim_led_o,
    output logic [15:0] ret_led_o,
    // Status lights
    output logic sync_led_o,
    output logic gref_led_o,
    output logic bat_led_o,
    output logic hv_led_o,
    // Control outputs and interrupt
    output logic [15:0] ctl_out_o,
    output logic [15:0] ctl_led_o,
    output logic irq_o
);

    stim_bank_pkg::ctrl_state_s s;
    stim_bank_pkg::ctrl_state_s next_s;
    logic [15:0] chan_mask;
    logic [15:0] stim_eff;
    logic [15:0] ret_eff;
    logic use_gref;
    logic [4:0] events;
    logic [4:0] clr;

    function automatic logic blink(input logic [11:0] ms, input logic [11:0] period);
        logic [11:0] m;
        m = ms % period;
        return m < (period >> 1);
    endfunction : blink

    // Shared by link control words and the register port
    function automatic stim_bank_pkg::ctrl_state_s cfg_write(
        input stim_bank_pkg::ctrl_state_s st,
        input logic [5:0] addr,
        input logic [15:0] data
    );
        stim_bank_pkg::ctrl_state_s r;
        r = st;
        unique case (addr)
            stim_bank_pkg::ADDR_STIM_SEL: r.stim_sel = data;
            stim_bank_pkg::ADDR_RET_SEL: r.ret_sel = data;
            stim_bank_pkg::ADDR_BANK_EN: r.bank_en = data[3:0];
            stim_bank_pkg::ADDR_CONFIG: r.global_ref = data[stim_bank_pkg::CFG_GLOBAL_REF_BIT];
            stim_bank_pkg::ADDR_DOUT: r.dout = data;
            default: r = st;
        endcase
        return r;
    endfunction : cfg_write

    assign chan_mask = (NUM_CH == 16) ? stim_bank_pkg::ALL_CH_MASK
                                      : stim_bank_pkg::FOUR_CH_MASK;
    // An all-zero return mask falls back to the global return path
    assign use_gref = s.global_ref | (s.ret_sel == 16'h0000);
    assign stim_eff = s.stim_sel & chan_mask;
    assign ret_eff = use_gref ? 16'h0000 : (s.ret_sel & chan_mask);

    always_comb begin
        next_s = s;
        events = 5'h00;
        clr = 5'h00;

        // Pins: three stages, level moves once stages two and three agree
        next_s.sync1 = pins_i;
        next_s.sync2 = s.sync1;
        next_s.sync3 = s.sync2;
        next_s.lvl = (s.sync2 & s.sync3) | (s.lvl & (s.sync2 | s.sync3));

        // Control words from the link, then the register port
        if (link_i.valid && link_i.is_ctrl) begin
            next_s = cfg_write(next_s, link_i.addr, link_i.data);
        end
        if (bus_i.wr) begin
            next_s = cfg_write(next_s, bus_i.addr, bus_i.wdata[15:0]);
            if (bus_i.addr == stim_bank_pkg::ADDR_INT_STAT) begin
                clr = bus_i.wdata[4:0];
            end
            if (bus_i.addr == stim_bank_pkg::ADDR_INT_MASK) begin
                next_s.int_mask = bus_i.wdata[4:0];
            end
        end

        // Bank conflict and power
        for (int b = 0; b < 4; b++) begin
            next_s.conflict[b] = |(stim_eff[4*b +: 4] & ret_eff[4*b +: 4]);
            next_s.bank_pwr[b] = s.bank_en[b] & ~next_s.conflict[b]
                & (b < NUM_CH / 4);
        end

        // Modes follow this cycle's bank power, so a conflict never leaks
        for (int i = 0; i < 16; i++) begin
            if (!next_s.bank_pwr[i / 4]) begin
                next_s.mode[i] = stim_bank_pkg::MODE_OPEN;
            end else if (stim_eff[i]) begin
                next_s.mode[i] = stim_bank_pkg::MODE_STIM;
            end else if (ret_eff[i]) begin
                next_s.mode[i] = stim_bank_pkg::MODE_RET;
            end else begin
                next_s.mode[i] = stim_bank_pkg::MODE_OPEN;
            end
        end

        // Millisecond divider, three-second frame covers every period
        if (s.ms_cnt >= MS_CYCLES - 1) begin
            next_s.ms_cnt = 32'h0000_0000;
            if (s.ms_time >= stim_bank_pkg::OFF_PERIOD_MS - 12'h001) begin
                next_s.ms_time = 12'h000;
            end else begin
                next_s.ms_time = s.ms_time + 12'h001;
            end
        end else begin
            next_s.ms_cnt = s.ms_cnt + 32'h0000_0001;
        end

        // Channel lights and channel state toward the base
        for (int i = 0; i < 16; i++) begin
            if (s.bank_pwr[i / 4]) begin
                next_s.stim_led[i] = (s.mode[i] == stim_bank_pkg::MODE_STIM);
            end else begin
                next_s.stim_led[i] = chan_mask[i]
                    & (s.ms_time < stim_bank_pkg::OFF_PULSE_MS);
            end
            next_s.ret_led[i] = (s.mode[i] == stim_bank_pkg::MODE_RET);
            next_s.chan_state[i] = (s.mode[i] == stim_bank_pkg::MODE_STIM);
            next_s.chan_state[16 + i] = (s.mode[i] == stim_bank_pkg::MODE_RET);
        end

        // Status lights
        next_s.sync_led = s.lvl[0]
            | blink(s.ms_time, stim_bank_pkg::SYNC_PERIOD_MS);
        next_s.gref_led = use_gref;
        if (s.lvl[1]) begin
            next_s.bat_led = blink(s.ms_time, stim_bank_pkg::FAST_PERIOD_MS);
        end else if (s.lvl[2]) begin
            next_s.bat_led = blink(s.ms_time, stim_bank_pkg::SLOW_PERIOD_MS);
        end else begin
            next_s.bat_led = 1'b0;
        end
        if (s.lvl[3]) begin
            next_s.hv_led = 1'b1;
        end else if (s.lvl[4]) begin
            next_s.hv_led = blink(s.ms_time, stim_bank_pkg::HV_PERIOD_MS);
        end else begin
            next_s.hv_led = 1'b0;
        end
        next_s.ctl_led = s.dout;

        // Samples pass straight to the converters
        next_s.dac_valid = link_i.valid & ~link_i.is_ctrl;
        next_s.dac_data = link_i.valid ? link_i.data : s.dac_data;

        // Sticky events; a set in the clearing cycle survives
        events[stim_bank_pkg::EV_CONFLICT] = |(next_s.conflict & ~s.conflict);
        events[stim_bank_pkg::EV_LINK_LOST] = s.lvl[0] & ~next_s.lvl[0];
        events[stim_bank_pkg::EV_LINK_UP] = ~s.lvl[0] & next_s.lvl[0];
        events[stim_bank_pkg::EV_BAT_LOW] = ~s.lvl[2] & next_s.lvl[2];
        events[stim_bank_pkg::EV_HV_LOW] = ~s.lvl[4] & next_s.lvl[4];
        next_s.int_stat = (s.int_stat & ~clr) | events;
        next_s.irq = |(s.int_stat & s.int_mask);

        // Read data stands only in the cycle after the strobe
        next_s.rdata = 32'h0000_0000;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                stim_bank_pkg::ADDR_STIM_SEL: next_s.rdata = {16'h0000, s.stim_sel};
                stim_bank_pkg::ADDR_RET_SEL: next_s.rdata = {16'h0000, s.ret_sel};
                stim_bank_pkg::ADDR_BANK_EN: next_s.rdata = {28'h0000000, s.bank_en};
                stim_bank_pkg::ADDR_CONFIG: next_s.rdata = {31'h00000000, s.global_ref};
                stim_bank_pkg::ADDR_DOUT: next_s.rdata = {16'h0000, s.dout};
                stim_bank_pkg::ADDR_STATUS:
                    next_s.rdata = {19'h00000, s.bank_pwr, s.conflict, s.lvl};
                stim_bank_pkg::ADDR_INT_STAT: next_s.rdata = {27'h0000000, s.int_stat};
                stim_bank_pkg::ADDR_INT_MASK: next_s.rdata = {27'h0000000, s.int_mask};
                stim_bank_pkg::ADDR_CHAN_STATE: next_s.rdata = s.chan_state;
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            s <= stim_bank_pkg::STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o = s.rdata;
    assign chan_state_o = s.chan_state;
    assign dac_valid_o = s.dac_valid;
    assign dac_data_o = s.dac_data;
    assign bank_pwr_o = s.bank_pwr;
    assign stim_led_o = s.stim_led;
    assign ret_led_o = s.ret_led;
    assign sync_led_o = s.sync_led;
    assign gref_led_o = s.gref_led;
    assign bat_led_o = s.bat_led;
    assign hv_led_o = s.hv_led;
    assign ctl_out_o = s.dout;
    assign ctl_led_o = s.ctl_led;
    assign irq_o = s.irq;

    property p_conflict_off;
        @(posedge clock_i) disable iff (reset_i)
        (next_s.conflict != 4'h0) |=> ((bank_pwr_o & s.conflict) == 4'h0);
    endproperty
    a_conflict_off: assert property (p_conflict_off)
        else $error("conflicting bank still powered");

    property p_one_mode;
        @(posedge clock_i) disable iff (reset_i)
        (chan_state_o[15:0] & chan_state_o[31:16]) == 16'h0000;
    endproperty
    a_one_mode: assert property (p_one_mode)
        else $error("channel in two modes");

    property p_stim_led;
        @(posedge clock_i) disable iff (reset_i)
        (bank_pwr_o == 4'hf) ##1 (bank_pwr_o == 4'hf)
            |=> (stim_led_o == chan_state_o[15:0]);
    endproperty
    a_stim_led: assert property (p_stim_led)
        else $error("stim light does not follow channel");

    property p_off_pulse;
        @(posedge clock_i) disable iff (reset_i)
        (s.bank_pwr[0] == 1'b0 && s.ms_time >= stim_bank_pkg::OFF_PULSE_MS)
            |=> (stim_led_o[3:0] == 4'h0);
    endproperty
    a_off_pulse: assert property (p_off_pulse)
        else $error("off bank light outside pulse");

    property p_ref_led;
        @(posedge clock_i) disable iff (reset_i)
        ret_led_o == chan_state_o[31:16];
    endproperty
    a_ref_led: assert property (p_ref_led)
        else $error("ref light mismatch");

    property p_sync_steady;
        @(posedge clock_i) disable iff (reset_i)
        s.lvl[0] [*2] |-> sync_led_o;
    endproperty
    a_sync_steady: assert property (p_sync_steady)
        else $error("link light not steady");

    property p_gref;
        @(posedge clock_i) disable iff (reset_i)
        (bus_i.wr && bus_i.addr == stim_bank_pkg::ADDR_RET_SEL && bus_i.wdata[15:0] != 16'h0000)
            ##1 !bus_i.wr [*2] |=> (gref_led_o == s.global_ref);
    endproperty
    a_gref: assert property (p_gref)
        else $error("global reference light wrong");

    property p_dout;
        @(posedge clock_i) disable iff (reset_i)
        (bus_i.wr && bus_i.addr == stim_bank_pkg::ADDR_DOUT)
            |=> (ctl_out_o == $past(bus_i.wdata[15:0])) ##1 (ctl_led_o == $past(ctl_out_o));
    endproperty
    a_dout: assert property (p_dout)
        else $error("control output or light wrong");

    property p_irq;
        @(posedge clock_i) disable iff (reset_i)
        ((s.int_stat & s.int_mask) != 5'h00) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    c_conflict: cover property (@(posedge clock_i) disable iff (reset_i)
        s.conflict != 4'h0);
    c_link_up: cover property (@(posedge clock_i) disable iff (reset_i)
        $rose(sync_led_o) ##1 s.lvl[0]);
    c_sample: cover property (@(posedge clock_i) disable iff (reset_i)
        dac_valid_o ##1 dac_valid_o);

endmodule : stim_bank_ctrl

`default_nettype wire

/* File: verification/base_station_model.sv */
// Purpose: Base station end of the fiber link, words already deserialised
// Assumes: A word is taken on the edge after it is raised
// Notes: Idle fields carry the inverse of the last word, never a stale copy
`timescale 1ns/1ps
`default_nettype none

module base_station_model (
    // Clock
    input wire logic clock_i,
    // Words toward the device
    output var stim_bank_pkg::link_word_s link_o
);
    initial link_o = '0;

    // Samples and control words share one path
    // Each word is followed by one idle cycle, as from a base station below the link rate
    task automatic send(input logic ctrl, input logic [5:0] addr, input logic [15:0] data);
        @(posedge clock_i);
        link_o <= '{valid: 1'b1, is_ctrl: ctrl, addr: addr, data: data};
        @(posedge clock_i);
        link_o <= '{valid: 1'b0, is_ctrl: ~ctrl, addr: ~addr, data: ~data};
    endtask : send
endmodule : base_station_model

`default_nettype wire

/* File: verification/test_stim_bank_ctrl.sv */
// Purpose: Self-checking bench for the stimulator bank control
// Assumes: One ms shortened to four clocks so blink periods stay short
// Notes: Blink checks measure rise-to-rise periods, not duty
`timescale 1ns/1ps
`default_nettype none

module test_stim_bank_ctrl;
    localparam int MS = 4;
    localparam int LIMIT = 80000;
    logic clock_i;
    logic reset_i;
    stim_bank_pkg::bus_req_s bus;
    stim_bank_pkg::link_word_s link;
    stim_bank_pkg::status_pins_s pins;
    logic [31:0] rdata, chan_state;
    logic dac_valid, sync_led, gref_led, bat_led, hv_led, irq;
    logic [15:0] dac_data, stim_led, ret_led, ctl_out, ctl_led;
    logic [3:0] bank_pwr;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;

    stim_bank_ctrl #(.NUM_CH(16), .MS_CYCLES(MS)) dut_u (
        .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus), .rdata_o(rdata),
        .link_i(link), .chan_state_o(chan_state), .dac_valid_o(dac_valid),
        .dac_data_o(dac_data), .pins_i(pins), .bank_pwr_o(bank_pwr),
        .stim_led_o(stim_led), .ret_led_o(ret_led), .sync_led_o(sync_led),
        .gref_led_o(gref_led), .bat_led_o(bat_led), .hv_led_o(hv_led),
        .ctl_out_o(ctl_out), .ctl_led_o(ctl_led), .irq_o(irq)
    );

    base_station_model base_u (.clock_i(clock_i), .link_o(link));

    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic tally_and_finish();
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    // A hung wait lands here instead of running forever
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h", $time, msg, got);
        end
    endtask : check

    task automatic bus_write(input logic [5:0] addr, input logic [31:0] data);
        @(posedge clock_i);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clock_i);
        bus <= '0;
    endtask : bus_write

    task automatic expect_reg(input logic [5:0] addr, input logic [31:0] exp, input string msg);
        @(posedge clock_i);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 32'h00000000};
        @(posedge clock_i);
        bus <= '0;
        #1;
        check(rdata, exp, msg);
    endtask : expect_reg

    function automatic logic led(input int sel);
        case (sel)
            0: return sync_led;
            1: return bat_led;
            2: return hv_led;
            default: return stim_led[0];
        endcase
    endfunction : led

    // Clocks from one rise of a light to the next
    task automatic period_of(input int sel, input int lim, output int p);
        int n;
        for (n = 0; n < lim && led(sel) !== 1'b0; n++) tick(1);
        for (n = 0; n < lim && led(sel) !== 1'b1; n++) tick(1);
        for (p = 0; p < lim && led(sel) !== 1'b0; p++) tick(1);
        for (; p < lim && led(sel) !== 1'b1; p++) tick(1);
    endtask : period_of

    task automatic t_reset();
        check(chan_state, 32'h00000000, "channels not open");
        bus_write(6'h3c, 32'hffffffff);
        bus_write(stim_bank_pkg::ADDR_CHAN_STATE, 32'hffffffff);
        expect_reg(6'h3c, 32'h00000000, "unmapped read");
        expect_reg(stim_bank_pkg::ADDR_CHAN_STATE, 32'h00000000, "read-only written");
        expect_reg(stim_bank_pkg::ADDR_BANK_EN, 32'h0000000f, "bank enable reset");
        check(bank_pwr, 4'hf, "banks not powered");
    endtask : t_reset

    task automatic t_modes();
        base_u.send(1'b1, stim_bank_pkg::ADDR_STIM_SEL, 16'h8007);
        tick(6);
        check(stim_led, 16'h8007, "stim lights");
        check(chan_state, 32'h00008007, "stim mask");
        bus_write(stim_bank_pkg::ADDR_RET_SEL, 32'h00000070);
        tick(6);
        check(ret_led, 16'h0070, "ref lights");
        check(chan_state, 32'h00708007, "modes");
        check(gref_led, 1'b0, "global light with local ref");
        bus_write(stim_bank_pkg::ADDR_CONFIG, 32'h00000001);
        tick(6);
        check({gref_led, ret_led}, 17'h10000, "global ref");
        bus_write(stim_bank_pkg::ADDR_CONFIG, 32'h00000000);
    endtask : t_modes

    task automatic t_conflict();
        int p;
        bus_write(stim_bank_pkg::ADDR_INT_MASK, 32'h00000001);
        bus_write(stim_bank_pkg::ADDR_RET_SEL, 32'h00000001);
        tick(6);
        check(bank_pwr, 4'he, "bank 0 not shut");
        check(chan_state, 32'h00008000, "bank 0 channels");
        check(irq, 1'b1, "conflict interrupt");
        period_of(3, 30000, p);
        check(p, int'(stim_bank_pkg::OFF_PERIOD_MS) * MS, "off bank pulse");
        bus_write(stim_bank_pkg::ADDR_INT_STAT, 32'h00000001);
        tick(2);
        check(irq, 1'b0, "interrupt clear");
        bus_write(stim_bank_pkg::ADDR_RET_SEL, 32'h00000000);
        bus_write(stim_bank_pkg::ADDR_BANK_EN, 32'h0000000d);
        tick(6);
        check(bank_pwr, 4'hd, "bank enable");
        // Bank 1 is now off and still inside its pulse after the frame start
        check(stim_led, 16'h80f7, "stim restored");
        bus_write(stim_bank_pkg::ADDR_BANK_EN, 32'h0000000f);
    endtask : t_conflict

    task automatic t_status();
        int p;
        period_of(0, 10000, p);
        check(p, int'(stim_bank_pkg::SYNC_PERIOD_MS) * MS, "sync blink");
        pins.link_ok <= 1'b1;
        tick(10);
        check(sync_led, 1'b1, "sync steady");
        tick(3000);
        check(sync_led, 1'b1, "sync steady later");
        expect_reg(stim_bank_pkg::ADDR_INT_STAT, 32'h00000004, "link up event");
        pins.bat_chg <= 1'b1;
        tick(10);
        period_of(1, 4000, p);
        check(p, int'(stim_bank_pkg::FAST_PERIOD_MS) * MS, "charge blink");
        pins.bat_chg <= 1'b0;
        pins.bat_low <= 1'b1;
        tick(10);
        period_of(1, 14000, p);
        check(p, int'(stim_bank_pkg::SLOW_PERIOD_MS) * MS, "low battery blink");
        pins.hv_low <= 1'b1;
        tick(10);
        period_of(2, 6000, p);
        check(p, int'(stim_bank_pkg::HV_PERIOD_MS) * MS, "low voltage blink");
        pins.hv_ok <= 1'b1;
        tick(10);
        check(hv_led, 1'b1, "voltage steady");
        tick(3000);
        check(hv_led, 1'b1, "voltage steady later");
    endtask : t_status

    task automatic t_ctl();
        bus_write(stim_bank_pkg::ADDR_DOUT, 32'hffffa5c3);
        #1;
        check(ctl_out, 16'ha5c3, "control word");
        tick(1);
        check(ctl_led, 16'ha5c3, "control lights");
        base_u.send(1'b1, stim_bank_pkg::ADDR_DOUT, 16'h8001);
        #1;
        check(ctl_out, 16'h8001, "control word by link");
        tick(1);
        check(ctl_led, 16'h8001, "control lights by link");
        expect_reg(stim_bank_pkg::ADDR_DOUT, 32'h00008001, "control readback");
    endtask : t_ctl

    task automatic t_samples();
        base_u.send(1'b0, 6'h00, 16'h1234);
        #1;
        check({dac_valid, dac_data}, 17'h11234, "first sample");
        base_u.send(1'b0, 6'h00, 16'habcd);
        #1;
        check({dac_valid, dac_data}, 17'h1abcd, "second sample");
        tick(1);
        check({dac_valid, dac_data}, 17'h0abcd, "sample hold");
        check(stim_led, 16'h8007, "sample touched modes");
    endtask : t_samples

    initial begin
        bus = '0;
        pins = '0;
        reset_i = 1'b1;
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b0;
        tick(3);
        t_reset();
        t_modes();
        t_conflict();
        t_ctl();
        t_samples();
        t_status();
        tally_and_finish();
    end
endmodule : test_stim_bank_ctrl

`default_nettype wire
